// File: hdl/aperture_delay_pkg.sv
/*
 * constants for the aperture delay and sysref window block: delay code
 * widths, ramp timing, sysref sampling positions and delay scaling.
 * assumes one device clock domain and an active low asynchronous reset.
 */
package aperture_delay_pkg;

    // --------------------------------------------------------------
    // delay code layout
    // --------------------------------------------------------------
    localparam int DELAY_BITS      = 8;      // 256 settings each
    localparam int DELAY_SUM_BITS  = 32;     // summed delay, femtoseconds

    // scale of each delay in femtoseconds; plain defaults
    localparam logic [31:0] HALF_PERIOD_FS  = 32'h0000_0000 + 32'd25000000;
    localparam logic [31:0] COARSE_STEP_FS  = 32'd1000;
    localparam logic [31:0] FINE_STEP_FS    = 32'd20;

    // --------------------------------------------------------------
    // ramp timing
    // --------------------------------------------------------------
    localparam int          RAMP_PERIOD_CYCLES = 256; // cycles per step
    localparam logic [7:0]  RAMP_SLOW_STEP     = 8'h01;
    localparam logic [7:0]  RAMP_FAST_STEP     = 8'h04;

    // --------------------------------------------------------------
    // sysref window
    // --------------------------------------------------------------
    localparam int          POSITION_COUNT  = 24; // detector positions
    localparam int          SELECT_BITS     = 4;  // reaches positions 0..15
    localparam logic [1:0]  EDGES_FOR_VALID = 2'h3;
    localparam int          POSITION_LAST   = POSITION_COUNT - 1;

endpackage

// File: hdl/aperture_delay_and_sysref_window.sv
/*
 * aperture delay control with coarse ramping, plus sysref position
 * detector and sampling position selection.
 * assumes the delayed device clock phases are sampled by the analog
 * delay line and arrive as a vector synchronous to clk; the applied
 * delay codes drive the analog delay elements on the clock path.
 */
module aperture_delay_and_sysref_window
    import aperture_delay_pkg::*;
#(
    parameter int RAMP_PERIOD = aperture_delay_pkg::RAMP_PERIOD_CYCLES
) (
    input  wire logic                                 clk,
    input  wire logic                                 resetn,
    input  wire logic                                 clockInvertDelay,
    input  wire logic [aperture_delay_pkg::DELAY_BITS-1:0] coarseDelaySetting,
    input  wire logic                                 coarseDelayWrite,
    input  wire logic [aperture_delay_pkg::DELAY_BITS-1:0] fineDelaySetting,
    input  wire logic                                 delayRampEnable,
    input  wire logic                                 delayRampRateSelect,
    input  wire logic                                 singleChannelMode,
    input  wire logic [aperture_delay_pkg::POSITION_COUNT-1:0] sysrefPhase,
    input  wire logic [aperture_delay_pkg::SELECT_BITS-1:0] sysrefPositionSelect,
    output logic                                      appliedInvert,
    output logic [aperture_delay_pkg::DELAY_BITS-1:0] appliedCoarse,
    output logic [aperture_delay_pkg::DELAY_BITS-1:0] appliedFine,
    output logic [aperture_delay_pkg::DELAY_SUM_BITS-1:0] apertureDelay,
    output logic                                      rampBusy,
    output logic                                      bothEdgeSampling,
    output logic [aperture_delay_pkg::POSITION_COUNT-1:0] sysrefPositionStatus,
    output logic                                      sysrefPositionValid,
    output logic                                      sysrefCaptured
);
    import aperture_delay_pkg::*;

    // --------------------------------------------------------------
    // elaboration checks
    // --------------------------------------------------------------
    // tick counter is eight bits wide
    if (RAMP_PERIOD < 2 || RAMP_PERIOD > 256) begin : g_bad_period
        $error("RAMP_PERIOD must lie in 2..256");
    end

    localparam logic [7:0] TICK_LAST = 8'(RAMP_PERIOD - 1);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic                      inv;       // applied inversion
        logic [DELAY_BITS-1:0]     coarse;    // applied coarse code
        logic [DELAY_BITS-1:0]     target;    // last written coarse code
        logic [DELAY_BITS-1:0]     fine;      // applied fine code
        logic [7:0]                tick;      // ramp interval counter
        logic [DELAY_SUM_BITS-1:0] delaySum;  // total delay, fs
        logic                      both;      // dual edge sampling
        logic [POSITION_COUNT-1:0] prevPhase; // last phase samples
        logic [POSITION_COUNT-1:0] status;    // sticky violation map
        logic [1:0]                edges;     // saturating edge count
        logic                      capture;   // selected phase rose
    } state_s;

    state_s st;       // registered state
    state_s next_st;  // next state

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        logic [DELAY_BITS-1:0]     diff;
        logic [DELAY_BITS-1:0]     step;
        logic [POSITION_COUNT-1:0] flag;
        diff    = '0;
        step    = '0;
        flag    = '0;
        next_st = st;

        // inversion and fine codes follow their controls directly
        next_st.inv  = clockInvertDelay;
        next_st.fine = fineDelaySetting;

        // coarse path: immediate or ramped
        if (coarseDelayWrite) begin
            next_st.target = coarseDelaySetting;
            next_st.tick   = '0;                             // new ramp
            if (!delayRampEnable) begin
                next_st.coarse = coarseDelaySetting;
            end
        end else if (delayRampEnable && st.coarse != st.target) begin
            // jumps would glitch the internal clocks, so step slowly
            if (st.tick == TICK_LAST) begin
                next_st.tick = '0;
                step = delayRampRateSelect ? RAMP_FAST_STEP
                                           : RAMP_SLOW_STEP;
                if (st.coarse < st.target) begin
                    diff = st.target - st.coarse;
                    // clamp so the last step lands on target
                    next_st.coarse = st.coarse
                        + ((diff < step) ? diff : step);
                end else begin
                    diff = st.coarse - st.target;
                    next_st.coarse = st.coarse
                        - ((diff < step) ? diff : step);
                end
            end else begin
                next_st.tick = st.tick + 8'h01;
            end
        end else if (!delayRampEnable) begin
            // ramp switched off mid-way: settle on target at once
            next_st.coarse = st.target;
            next_st.tick   = '0;
        end else begin
            next_st.tick = '0;
        end

        // delays add; one figure steers every internal clock
        next_st.delaySum = (st.inv ? HALF_PERIOD_FS : 32'h0)
            + 32'(st.coarse) * COARSE_STEP_FS
            + 32'(st.fine) * FINE_STEP_FS;

        // sampling edges follow the channel mode
        next_st.both = singleChannelMode;

        // position detector: a transition between two neighbouring
        // phases puts both neighbours at risk of setup or hold trouble
        for (int i = 0; i < POSITION_LAST; i++) begin
            if (sysrefPhase[i] != sysrefPhase[i+1]) begin
                flag[i]   = 1'b1;
                flag[i+1] = 1'b1;
            end
        end
        next_st.status = st.status | flag;
        // edge positions have unknown margin
        next_st.status[0]             = 1'b1;
        next_st.status[POSITION_LAST] = 1'b1;
        next_st.prevPhase = sysrefPhase;

        // count sysref rising edges seen on the earliest phase
        if (sysrefPhase[0] && !st.prevPhase[0]
                && st.edges != EDGES_FOR_VALID) begin
            next_st.edges = st.edges + 2'h1;
        end

        // capture on the chosen delayed phase, one fixed clock later
        next_st.capture = sysrefPhase[sysrefPositionSelect]
            && !st.prevPhase[sysrefPositionSelect];
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st        <= '0;
            // only the edge positions start suspect; a fully set map
            // could never show a clear position, since it is sticky
            st.status[0]             <= 1'b1;
            st.status[POSITION_LAST] <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign appliedInvert        = st.inv;
    assign appliedCoarse        = st.coarse;
    assign appliedFine          = st.fine;
    assign apertureDelay        = st.delaySum;
    assign rampBusy             = st.coarse != st.target;
    assign bothEdgeSampling     = st.both;
    assign sysrefPositionStatus = st.status;
    assign sysrefPositionValid  = st.edges == EDGES_FOR_VALID;
    assign sysrefCaptured       = st.capture;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_direct_write;
        coarseDelayWrite && !delayRampEnable;
    endsequence
    sequence s_ramp_idle;
        !coarseDelayWrite && delayRampEnable && rampBusy;
    endsequence

    a_direct_coarse: assert property (s_direct_write |=>
        appliedCoarse == $past(coarseDelaySetting))
        else $error("direct coarse write not applied");
    a_ramp_write_hold: assert property (coarseDelayWrite && delayRampEnable
        |=> appliedCoarse == $past(appliedCoarse))
        else $error("ramped write jumped coarse code");
    a_ramp_step_size: assert property (s_ramp_idle ##1 1 |->
        (appliedCoarse > $past(appliedCoarse)
            ? appliedCoarse - $past(appliedCoarse)
            : $past(appliedCoarse) - appliedCoarse) <= 8'h04)
        else $error("ramp step too large");
    a_ramp_no_overshoot: assert property (!rampBusy && delayRampEnable
        && !coarseDelayWrite |=> !rampBusy)
        else $error("ramp moved past target");
    a_ramp_no_jump: assert property ((s_ramp_idle and
        (st.tick != TICK_LAST)) |=> $stable(appliedCoarse))
        else $error("coarse code changed between ticks");
    a_invert_sum: assert property (appliedInvert && appliedCoarse == 8'h00
        && appliedFine == 8'h00 && $stable(appliedInvert)
        && $stable(appliedCoarse) && $stable(appliedFine)
        |=> apertureDelay == HALF_PERIOD_FS)
        else $error("inversion delay not half period");
    a_delay_adds: assert property (##1 apertureDelay ==
        ($past(appliedInvert) ? HALF_PERIOD_FS : 32'h0)
        + 32'($past(appliedCoarse)) * COARSE_STEP_FS
        + 32'($past(appliedFine)) * FINE_STEP_FS)
        else $error("delays do not add");
    a_edge_bits_set: assert property (sysrefPositionStatus[0]
        && sysrefPositionStatus[POSITION_LAST])
        else $error("edge status bits not set");
    a_valid_sticky: assert property (sysrefPositionValid |=>
        sysrefPositionValid)
        else $error("status valid dropped");
    a_capture_select: assert property (sysrefCaptured |->
        $past(sysrefPhase[sysrefPositionSelect])
        && !$past(st.prevPhase[sysrefPositionSelect]))
        else $error("capture not from selected phase");
    a_edges_mode: assert property (##1 bothEdgeSampling ==
        $past(singleChannelMode))
        else $error("sampling edge mode wrong");

endmodule // aperture_delay_and_sysref_window

// File: verification/sysref_source.sv
/*
 * model of the external clock source: sends one sysref pulse, as seen
 * through the 24 delayed device clock phases, each time fire is seen.
 * assumes fire pulses are at least four clk cycles apart.
 */
module sysref_source (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        fire,
    input  wire logic [4:0]  pos,
    output logic      [23:0] sysrefPhase
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // pulse shape
    // ------------------------------------------------------------
    logic [1:0]  stage;  // 0 idle, 1 rising, 2 high, 3 falling
    logic [23:0] rise;   // phases at and after pos see the edge

    assign rise = 24'hffffff << pos;

    // edge lands between phase pos-1 and pos, on rise and fall alike;
    // a released line reads low, as the source drives zero between
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage       <= 2'h0;
            sysrefPhase <= 24'h000000;
        end else begin
            case (stage)
                2'h0: if (fire) begin
                    sysrefPhase <= rise;
                    stage       <= 2'h1;
                end
                2'h1: begin
                    sysrefPhase <= 24'hffffff;
                    stage       <= 2'h2;
                end
                2'h2: begin
                    sysrefPhase <= ~rise;
                    stage       <= 2'h3;
                end
                default: begin
                    sysrefPhase <= 24'h000000;
                    stage       <= 2'h0;
                end
            endcase
        end
    end
endmodule // sysref_source

// File: verification/aperture_delay_and_sysref_window_bench.sv
/*
 * self-checking bench: delay codes, coarse ramping, sysref window.
 * assumes the design package and a shortened ramp period of 8 cycles.
 */
module aperture_delay_and_sysref_window_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import aperture_delay_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int RP = 8;  // short ramp period keeps the run brief
    typedef struct {logic [7:0] val; int at;} note_s;
    logic clk = 1'b0, resetn, clockInvertDelay, coarseDelayWrite, fire;
    logic delayRampEnable, delayRampRateSelect, singleChannelMode;
    logic [7:0]  coarseDelaySetting, fineDelaySetting, appliedCoarse;
    logic [7:0]  appliedFine, lastCoarse = 8'h00;
    logic [23:0] sysrefPhase, sysrefPositionStatus;
    logic [31:0] apertureDelay;
    logic [4:0]  pos;
    logic [3:0]  sysrefPositionSelect;
    logic        appliedInvert, rampBusy, bothEdgeSampling;
    logic        sysrefPositionValid, sysrefCaptured;
    int          cyc = 0, nMismatch = 0, checksDone = 0;
    note_s       coarseQ[$];  // expected coarse steps with cycle
    int          capQ[$];     // expected capture cycles

    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    aperture_delay_and_sysref_window #(.RAMP_PERIOD(RP)) uut (
        .clk, .resetn, .clockInvertDelay, .coarseDelaySetting,
        .coarseDelayWrite, .fineDelaySetting, .delayRampEnable,
        .delayRampRateSelect, .singleChannelMode, .sysrefPhase,
        .sysrefPositionSelect, .appliedInvert, .appliedCoarse,
        .appliedFine, .apertureDelay, .rampBusy, .bothEdgeSampling,
        .sysrefPositionStatus, .sysrefPositionValid, .sysrefCaptured);

    sysref_source src (.clk, .resetn, .fire, .pos, .sysrefPhase);

    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic finish_test;
        if (nMismatch == 0 && checksDone > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // watches outputs just after each edge, takes the oldest note
    always @(posedge clk) begin
        note_s n;
        #1;
        if (resetn && sysrefCaptured) begin
            if (capQ.size() == 0) chk("spurious capture", 32'h0, 32'h1);
            else chk("capture cycle", capQ.pop_front(), cyc);
        end
        if (resetn && appliedCoarse !== lastCoarse) begin
            if (coarseQ.size() != 0) n = coarseQ.pop_front();
            else n = '{val: 8'hxx, at: -1};  // unexpected change
            chk("coarse value", n.val, appliedCoarse);
            chk("coarse cycle", n.at, cyc);
            lastCoarse = appliedCoarse;
        end
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    // coarse write; notes every step the ramp should take from now
    task automatic coarse(input logic [7:0] t, input logic rmp,
                          input logic rt);
        int k, i, st;
        logic [7:0] v;
        note_s n;
        @(posedge clk);
        k = cyc;
        st = rt ? 4 : 1;
        v = lastCoarse;
        coarseQ.delete();  // a rewrite drops the old ramp's steps
        coarseDelaySetting  <= t;
        coarseDelayWrite    <= 1'b1;
        delayRampEnable     <= rmp;
        delayRampRateSelect <= rt;
        for (i = 1; v != t; i++) begin
            if (!rmp) v = t;
            else if (t > v) v = (t - v > st) ? v + 8'(st) : t;
            else v = (v - t > st) ? v - 8'(st) : t;
            n.val = v;
            n.at = rmp ? k + 2 + i * RP : k + 2;
            coarseQ.push_back(n);
        end
        @(posedge clk);
        coarseDelayWrite <= 1'b0;
    endtask

    task automatic drain;
        // a wrapped fast ramp may need 64 steps of RP cycles each
        for (int j = 0; j < 600 && coarseQ.size() != 0; j++) @(posedge clk);
        chk("steps left", 32'h0, coarseQ.size());
    endtask

    // one sysref pulse; capture is one edge after the selected rise
    task automatic pulse(input logic [4:0] p, input logic [3:0] s);
        int k;
        @(posedge clk);
        k = cyc;
        fire <= 1'b1;
        capQ.push_back(k + 3 + int'(s < p));
        @(posedge clk);
        fire <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    initial begin
        logic [4:0] p;
        logic [3:0] s;
        logic [7:0] t, fn;
        logic iv;
        int q;
        {resetn, clockInvertDelay, coarseDelayWrite, fire} = 4'h0;
        {delayRampEnable, delayRampRateSelect, singleChannelMode} = 3'h0;
        {coarseDelaySetting, fineDelaySetting} = 16'h0000;
        {pos, sysrefPositionSelect} = 9'h000;
        void'($urandom(54));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        // sysref window: four pulses at a random position
        p = 5'(3 + $urandom % 18);
        s = 4'($urandom % 16);
        q = (p > 16) ? p - 6 : p + 6;
        @(posedge clk);
        pos <= p;
        sysrefPositionSelect <= s;
        pulse(p, s);
        pulse(p, s);
        chk("valid early", 32'h0, sysrefPositionValid);
        pulse(p, s);
        chk("valid", 32'h1, sysrefPositionValid);
        chk("ends", 32'h3,
            {sysrefPositionStatus[23], sysrefPositionStatus[0]});
        chk("edge", 32'h3,
            {sysrefPositionStatus[p], sysrefPositionStatus[p-1]});
        chk("clear", 32'h0, sysrefPositionStatus[q]);
        // software picks the middle of the clear stretch below the edge
        s = 4'((p - 5'h01) / 2);
        sysrefPositionSelect <= s;
        pulse(p, s);
        // direct delays, ramp off, highest code first
        for (int i = 0; i < 4; i++) begin
            iv = 1'($urandom);
            fn = 8'($urandom);
            t = (i == 0) ? 8'hff : lastCoarse + 8'(1 + $urandom % 200);
            clockInvertDelay <= iv;
            fineDelaySetting <= fn;
            coarse(t, 1'b0, 1'b0);
            repeat (4) @(posedge clk);
            chk("fine", fn, appliedFine);
            chk("invert", iv, appliedInvert);
            chk("delay", iv * HALF_PERIOD_FS + t * COARSE_STEP_FS
                + fn * FINE_STEP_FS, apertureDelay);
        end
        // slow ramp up by 10 (down to 0x20 from above 0xf0), rewritten mid-way into a fast ramp down
        t = (lastCoarse > 8'hf0) ? 8'h20 : lastCoarse + 8'h0a;
        coarse(t, 1'b1, 1'b0);
        @(posedge clk);
        chk("busy", 32'h1, rampBusy);
        while (coarseQ.size() > 7 || rampBusy !== 1'b1) @(posedge clk);
        coarse(lastCoarse - 8'h09, 1'b1, 1'b1);
        drain();
        chk("idle", 32'h0, rampBusy);
        // ramp switched off before its first step: applied code jumps to target
        t = lastCoarse + 8'h30;
        coarse(t, 1'b1, 1'b0);
        coarseQ.delete();
        coarseQ.push_back(note_s'{t, cyc + 2});
        delayRampEnable <= 1'b0;
        repeat (3) @(posedge clk);
        chk("ramp off", t, appliedCoarse);
        chk("ramp off idle", 32'h0, rampBusy);
        // sampling on both edges follows channel mode
        singleChannelMode <= 1'b1;
        repeat (2) @(posedge clk);
        chk("both edges", 32'h1, bothEdgeSampling);
        singleChannelMode <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rising only", 32'h0, bothEdgeSampling);
        chk("captures left", 32'h0, capQ.size());
        finish_test();
    end

    // cuts a hang short well past the expected run length
    initial begin
        #(50 * 5000);
        nMismatch++;
        finish_test();
    end
endmodule // aperture_delay_and_sysref_window_bench
